// ===== rtl/eip_top.sv
// External interrupt pair: pin select, polarity, edge or level pending flags
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "eip_consts.svh"

module eip_top #(
	parameter int PIN_COUNT = `EIP_PIN_COUNT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire eip_pkg::eip_addr_t address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Port-0 pins
	input wire logic [PIN_COUNT-1:0] p0_pin_in,
	output logic [PIN_COUNT-1:0] p0_pin_out,
	output logic [PIN_COUNT-1:0] p0_pin_oe_n,
	// Crossbar peripheral drive per pin
	input wire logic [PIN_COUNT-1:0] xbar_dout,
	input wire logic [PIN_COUNT-1:0] xbar_drive,
	output logic [PIN_COUNT-1:0] crossbar_skip,
	// CPU side
	input wire logic irq_a_ack,
	input wire logic irq_b_ack,
	output logic ext_irq_a,
	output logic ext_irq_b,
	output logic irq
);
	import eip_pkg::*;

	// ********************
	// Parameter check
	// ********************
	// The select field is three bits, so exactly eight pins can be served
	if (PIN_COUNT != `EIP_PIN_COUNT) begin : g_bad_pins
		$error("eip_top: PIN_COUNT must be 8");
	end

	// ********************
	// Registers
	// ********************
	eip_byte_t cfg_q;
	eip_byte_t cfg_d;
	logic [1:0] trig_q;
	logic [1:0] trig_d;
	logic [PIN_COUNT-1:0] skip_q;
	logic [PIN_COUNT-1:0] skip_d;
	logic [1:0] mask_q;
	logic [1:0] mask_d;
	logic [1:0] stat_q;
	logic [1:0] stat_d;
	logic [1:0] pend_q;
	logic [1:0] pend_d;
	logic [1:0] act_q;
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic irq_q;
	logic [PIN_COUNT-1:0] pin_out_q;
	logic [PIN_COUNT-1:0] pin_oe_n_q;

	// ********************
	// Bus decode
	// ********************
	wire req = read | write;
	// First cycle of a request loads read data; second cycle releases it
	wire take = req & ~wait_q;
	wire wr_en = write & take & byteenable[0];
	wire hit_cfg = address == `EIP_OFS_CFG;
	wire hit_tc = address == `EIP_OFS_TMR_CTL;
	wire hit_skip = address == `EIP_OFS_SKIP;
	wire hit_stat = address == `EIP_OFS_STAT;
	wire hit_mask = address == `EIP_OFS_MASK;
	wire eip_byte_t wb = writedata[7:0];

	wire eip_byte_t tc_view = {4'h0, pend_q[1], trig_q[1], pend_q[0], trig_q[0]};
	wire eip_byte_t rd_byte;
	assign rd_byte = hit_cfg ? cfg_q :
		hit_tc ? tc_view :
		hit_skip ? skip_q :
		hit_stat ? {6'h00, stat_q} :
		hit_mask ? {6'h00, mask_q} : 8'h00;

	assign wait_d = ~(req & wait_q);
	assign rdata_d = (req & wait_q) ? {24'h000000, rd_byte} : rdata_q;

	// ********************
	// Register writes
	// ********************
	assign cfg_d = (wr_en & hit_cfg) ? wb : cfg_q;
	assign trig_d = (wr_en & hit_tc) ?
		{wb[`EIP_TC_B_TRIG], wb[`EIP_TC_A_TRIG]} : trig_q;
	assign skip_d = (wr_en & hit_skip) ? wb : skip_q;
	assign mask_d = (wr_en & hit_mask) ? wb[1:0] : mask_q;

	// ********************
	// Pin synchroniser
	// ********************
	logic [PIN_COUNT-1:0] s1_q;
	logic [PIN_COUNT-1:0] s2_q;
	logic [PIN_COUNT-1:0] s3_q;
	logic [PIN_COUNT-1:0] pin_f_q;

	for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
		always_ff @(posedge clk) begin
			if (!resetn) begin
				s1_q[p] <= 1'b1;
				s2_q[p] <= 1'b1;
				s3_q[p] <= 1'b1;
				pin_f_q[p] <= 1'b1;
			end else begin
				// Read only: sampling leaves pin drive untouched
				s1_q[p] <= p0_pin_in[p];
				s2_q[p] <= s1_q[p];
				s3_q[p] <= s2_q[p];
				// Change counts once two later stages agree
				if (s2_q[p] == s3_q[p]) begin
					pin_f_q[p] <= s3_q[p];
				end
			end
		end
	end

	// ********************
	// Channels
	// ********************
	wire eip_sel_t sel [2];
	assign sel[0] = cfg_q[`EIP_CFG_A_SEL_LSB +: `EIP_SEL_W];
	assign sel[1] = cfg_q[`EIP_CFG_B_SEL_LSB +: `EIP_SEL_W];
	wire [1:0] pol = {cfg_q[`EIP_CFG_B_POL], cfg_q[`EIP_CFG_A_POL]};
	wire [1:0] ack = {irq_b_ack, irq_a_ack};
	wire [1:0] act;
	wire [1:0] edge_hit;

	for (genvar c = 0; c < `EIP_CH_COUNT; c++) begin : g_ch
		// Polarity 1 keeps the level, 0 inverts it
		assign act[c] = pin_f_q[sel[c]] ~^ pol[c];
		assign edge_hit[c] = act[c] & ~act_q[c];
		// Edge: new edge beats a vector clear in the same cycle
		assign pend_d[c] = (eip_trig_t'(trig_q[c]) == EIP_EDGE) ?
			(edge_hit[c] | (pend_q[c] & ~ack[c])) :
			act[c];
	end

	// ********************
	// Interrupt status
	// ********************
	// Set wins over a write-one clear arriving together
	wire [1:0] stat_clr = (wr_en & hit_stat) ? wb[1:0] : 2'h0;
	assign stat_d = (stat_q & ~stat_clr) | edge_hit;

	// ********************
	// Crossbar pin drive
	// ********************
	// A skipped pin is not driven by a crossbar peripheral from one cycle after skip_q sets
	wire [PIN_COUNT-1:0] drive = xbar_drive & ~skip_q;

	// ********************
	// Configuration flop
	// ********************
	// Select and polarity share one byte, so both change in one write
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_q <= `EIP_CFG_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ********************
	// Trigger-type flops
	// ********************
	// Pending bits of the same byte are read-only, so only triggers store
	always_ff @(posedge clk) begin
		if (!resetn) begin
			trig_q <= `EIP_TC_RST;
		end else begin
			trig_q <= trig_d;
		end
	end

	// ********************
	// Crossbar skip flops
	// ********************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			skip_q <= `EIP_SKIP_RST;
		end else begin
			skip_q <= skip_d;
		end
	end

	// ********************
	// Mask flops
	// ********************
	// Masking only gates the summary line; status still records events
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mask_q <= `EIP_MASK_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	// ********************
	// Status flops
	// ********************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stat_q <= `EIP_STAT_RST;
		end else begin
			stat_q <= stat_d;
		end
	end

	// ********************
	// Pending flops
	// ********************
	// Level mode lags the filtered pin by this one register stage
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pend_q <= `EIP_PEND_RST;
		end else begin
			pend_q <= pend_d;
		end
	end

	// ********************
	// Active-level history
	// ********************
	// Reset to inactive, so an idle pin gives no false edge after reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			act_q <= 2'h0;
		end else begin
			act_q <= act;
		end
	end

	// ********************
	// Wait-state flop
	// ********************
	// High at rest; every request costs exactly one wait cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= wait_d;
		end
	end

	// ********************
	// Read data flops
	// ********************
	// Held between requests so a slow master still sees stable data
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ********************
	// Interrupt line flop
	// ********************
	// Uses next-state values so the line rises with the status bit
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_d & mask_d);
		end
	end

	// ********************
	// Pin data flops
	// ********************
	// Costs one cycle of latency on peripheral data, keeps outputs clean
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_out_q <= '0;
		end else begin
			pin_out_q <= xbar_dout;
		end
	end

	// ********************
	// Pin enable flops
	// ********************
	// All pins released during reset, so pull-ups set the idle level
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_oe_n_q <= '1;
		end else begin
			pin_oe_n_q <= ~drive;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign ext_irq_a = pend_q[0];
	assign ext_irq_b = pend_q[1];
	assign irq = irq_q;
	assign crossbar_skip = skip_q;
	assign p0_pin_out = pin_out_q;
	assign p0_pin_oe_n = pin_oe_n_q;
endmodule : eip_top

// ===== rtl/eip_consts.svh
// Offsets, field positions, reset values and sizes of the external interrupt pair
`ifndef EIP_CONSTS_SVH
`define EIP_CONSTS_SVH

// ********************
// Register byte offsets
// ********************
`define EIP_ADDR_W 8
`define EIP_OFS_TMR_CTL 8'h00
`define EIP_OFS_SKIP 8'h04
`define EIP_OFS_STAT 8'h08
`define EIP_OFS_MASK 8'h0c
`define EIP_OFS_CFG 8'hf4

// ********************
// Field positions
// ********************
`define EIP_CFG_A_SEL_LSB 0
`define EIP_CFG_A_POL 3
`define EIP_CFG_B_SEL_LSB 4
`define EIP_CFG_B_POL 7
`define EIP_TC_A_TRIG 0
`define EIP_TC_A_PEND 1
`define EIP_TC_B_TRIG 2
`define EIP_TC_B_PEND 3
`define EIP_ST_A_EDGE 0
`define EIP_ST_B_EDGE 1

// ********************
// Reset values
// ********************
`define EIP_CFG_RST 8'h01
`define EIP_TC_RST 2'h0
`define EIP_SKIP_RST 8'h00
`define EIP_MASK_RST 2'h0
`define EIP_PIN_RST 8'hff
`define EIP_STAT_RST 2'h0
`define EIP_PEND_RST 2'h0

// ********************
// Sizes
// ********************
`define EIP_PIN_COUNT 8
`define EIP_SEL_W 3
`define EIP_CH_COUNT 2

`endif

// ===== rtl/eip_pkg.sv
// Types shared by the external interrupt pair
package eip_pkg;
	`include "eip_consts.svh"

	typedef enum logic {EIP_LEVEL, EIP_EDGE} eip_trig_t;
	typedef logic [`EIP_SEL_W-1:0] eip_sel_t;
	typedef logic [7:0] eip_byte_t;
	typedef logic [`EIP_ADDR_W-1:0] eip_addr_t;
endpackage : eip_pkg

// ===== sim/eip_top_assertions.sv
// Port assertions of the external interrupt pair
`timescale 1ns/1ns
`include "eip_consts.svh"
module eip_top_assertions #(
	parameter int PIN_COUNT = 8
) (
	input wire logic clk, resetn, read, write, waitrequest, irq_a_ack, ext_irq_a, ext_irq_b,
	input wire eip_pkg::eip_addr_t address,
	input wire logic [31:0] writedata,
	input wire logic [PIN_COUNT-1:0] p0_pin_in, p0_pin_out, p0_pin_oe_n,
	input wire logic [PIN_COUNT-1:0] xbar_dout, xbar_drive, crossbar_skip
);
	import eip_pkg::*;
	logic [1:0] tc_q;
	logic [3:0] qt_q;
	// Trigger bits are internal, so shadow them from bus writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tc_q <= 2'h0;
			qt_q <= 4'h0;
		end else begin
			if (write && !waitrequest && address == `EIP_OFS_TMR_CTL)
				tc_q <= {writedata[2], writedata[0]};
			// Quiet cycles: no pin change, no write
			qt_q <= (write || !$stable(p0_pin_in)) ? 4'h0 : qt_q + 4'(qt_q != 4'hf);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_WAIT_ONE: assert property ($rose(read || write) |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest not low for one cycle");
	AST_PIN_OUT: assert property (p0_pin_out == $past(xbar_dout))
		else $error("pin out not a copy of crossbar data");
	AST_SKIP: assert property ($stable(crossbar_skip) |-> !(crossbar_skip & ~p0_pin_oe_n))
		else $error("skipped pin driven");
	AST_DRIVE: assert property ($stable(xbar_drive) && $stable(crossbar_skip)
		|-> ~p0_pin_oe_n == (xbar_drive & ~crossbar_skip))
		else $error("pin enable wrong");
	AST_A_HOLD: assert property (tc_q[0] && ext_irq_a && !irq_a_ack && !write |=> ext_irq_a)
		else $error("edge pending lost");
	AST_A_ACK: assert property (tc_q[0] && irq_a_ack && qt_q > 4'h9 |=> !ext_irq_a)
		else $error("edge pending not cleared");
	AST_LEVEL: assert property (!tc_q[0] && qt_q > 4'h9 |=> $stable(ext_irq_a))
		else $error("level pending moved");
	AST_CAUSE: assert property ($rose(ext_irq_b) |-> qt_q < 4'ha)
		else $error("pending set without pin change");
	cover property (tc_q[0] && irq_a_ack ##1 !ext_irq_a);
	cover property (!tc_q[0] && ext_irq_a);
	cover property ($rose(ext_irq_b));
endmodule : eip_top_assertions

bind eip_top eip_top_assertions #(.PIN_COUNT(PIN_COUNT)) u_eip_top_assertions (.*);

// ===== sim/eip_src.sv
// Interrupt sources on the port-0 pins, with weak pull-ups
`timescale 1ns/1ns
module eip_src (
	input wire logic clk,
	input wire logic [7:0] po, oe_n,
	output logic [7:0] pin
);
	logic [7:0] src_q = 8'hff;
	// Peripheral drive wins; released lines float up
	assign pin = (oe_n & src_q) | (~oe_n & po);
	// Held until the caller lets go
	task automatic drive(input int i, input logic v);
		@(posedge clk);
		src_q[i] <= v;
	endtask : drive
endmodule : eip_src

// ===== sim/testbench.sv
// Register and pin bench for the external interrupt pair
`timescale 1ns/1ns
`include "eip_consts.svh"
module testbench;
	import eip_pkg::*;
	localparam eip_addr_t TC = `EIP_OFS_TMR_CTL, ST = `EIP_OFS_STAT, CF = `EIP_OFS_CFG;
	logic clk = 1'h0, resetn = 1'h0, read = 1'h0, write = 1'h0;
	logic irq_a_ack = 1'h0, irq_b_ack = 1'h0, waitrequest, ext_irq_a, ext_irq_b, irq;
	eip_addr_t address = 8'h00;
	logic [31:0] writedata = 32'h0, readdata;
	logic [3:0] byteenable = 4'h1;
	logic [7:0] p0_pin_in, p0_pin_out, p0_pin_oe_n, crossbar_skip;
	logic [7:0] xbar_dout = 8'h00, xbar_drive = 8'h00;
	int mismatches = 0, checks_done = 0;
	eip_top u_eip_top (.*);
	eip_src u_eip_src (.clk(clk), .po(p0_pin_out), .oe_n(p0_pin_oe_n), .pin(p0_pin_in));
	always #4 clk = ~clk;
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Write v, or read and expect v
	task automatic bus(input logic wr, input eip_addr_t a, input eip_byte_t v);
		@(posedge clk);
		address <= a;
		writedata <= {24'h0, v};
		read <= !wr;
		write <= wr;
		do @(posedge clk); while (waitrequest !== 1'h0);
		read <= 1'h0;
		write <= 1'h0;
		if (!wr) chk("register", readdata[7:0], v);
	endtask : bus
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic ack(input logic b);
		@(posedge clk);
		irq_a_ack <= !b;
		irq_b_ack <= b;
		@(posedge clk);
		irq_a_ack <= 1'h0;
		irq_b_ack <= 1'h0;
		wt(1);
	endtask : ack
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		wt(4);
		bus(0, CF, `EIP_CFG_RST);
		bus(0, TC, 8'h00);
		bus(0, 8'h40, 8'h00);
		bus(1, TC, 8'h05);
		for (int s = 0; s < 8; s++) begin
			// Active low with idle pull-ups, so a new select is no edge
			bus(1, CF, {1'h0, 3'(7 - s), 1'h0, 3'(s)});
			u_eip_src.drive(s, 1'h0);
			wt(8);
			chk("a set", ext_irq_a, 1'h1);
			chk("b idle", ext_irq_b, 1'h0);
			u_eip_src.drive(s, 1'h1);
			wt(12);
			chk("a held", ext_irq_a, 1'h1);
			ack(0);
			chk("a ack", ext_irq_a, 1'h0);
			u_eip_src.drive(7 - s, 1'h0);
			wt(8);
			chk("b set", ext_irq_b, 1'h1);
			u_eip_src.drive(7 - s, 1'h1);
			ack(1);
			chk("b ack", ext_irq_b, 1'h0);
		end
		bus(1, CF, 8'h18);
		bus(1, TC, 8'h04);
		wt(8);
		chk("level on", ext_irq_a, 1'h1);
		bus(0, TC, 8'h06);
		ack(0);
		chk("level ack", ext_irq_a, 1'h1);
		u_eip_src.drive(0, 1'h0);
		wt(8);
		chk("level off", ext_irq_a, 1'h0);
		bus(1, ST, 8'h03);
		bus(0, ST, 8'h00);
		u_eip_src.drive(0, 1'h1);
		wt(8);
		chk("masked", irq, 1'h0);
		bus(0, ST, 8'h01);
		bus(1, `EIP_OFS_MASK, 8'h01);
		wt(2);
		chk("irq", irq, 1'h1);
		bus(1, ST, 8'h01);
		wt(2);
		chk("irq clr", irq, 1'h0);
		bus(1, CF, 8'h98);
		bus(1, TC, 8'h00);
		wt(8);
		chk("b level on", ext_irq_b, 1'h1);
		u_eip_src.drive(1, 1'h0);
		wt(8);
		chk("b level off", ext_irq_b, 1'h0);
		u_eip_src.drive(1, 1'h1);
		byteenable <= 4'h0;
		bus(1, `EIP_OFS_MASK, 8'h03);
		byteenable <= 4'h1;
		bus(0, `EIP_OFS_MASK, 8'h01);
		@(posedge clk);
		xbar_dout <= 8'ha5;
		xbar_drive <= 8'hf0;
		bus(1, `EIP_OFS_SKIP, 8'h30);
		bus(1, CF, 8'h0e);
		wt(8);
		chk("oe_n", p0_pin_oe_n, 8'h3f);
		chk("out", p0_pin_out, 8'ha5);
		chk("skip", crossbar_skip, 8'h30);
		chk("via xbar", ext_irq_a, 1'h0);
		wrap_up;
	end
endmodule : testbench
